// ---- core/schbp_defs.vh ----
// constants for the serial controller host bus port
`ifndef SCHBP_DEFS_VH
`define SCHBP_DEFS_VH
// ************************************************************
// register indices within each set
// ************************************************************
`define SCHBP_CORE_CMD_IDX     5'h00
`define SCHBP_CORE_DATA_IDX    5'h08
`define SCHBP_CORE_IVEC_IDX    5'h02
`define SCHBP_CORE_IEN_IDX     5'h01
`define SCHBP_CORE_MIE_IDX     5'h09
`define SCHBP_CORE_IPEND_IDX   5'h03
`define SCHBP_DMA_DMA_CMD_STATUS_ADDR_REG_IDX     5'h00
`define SCHBP_DMA_IVEC_IDX     5'h01
`define SCHBP_DMA_IEN_IDX      5'h02
`define SCHBP_DMA_MIE_IDX      5'h03
`define SCHBP_DMA_IPEND_IDX    5'h04
// ************************************************************
// field positions
// ************************************************************
`define SCHBP_PTR4_MSB         3
`define SCHBP_PTR5_MSB         4
`define SCHBP_CMD_RESET_IUS    5'h07
`define SCHBP_CMD_CODE_LSB     3
`define SCHBP_CMD_SHIFT_BIT    0
`define SCHBP_BCR_SHIFT_BIT    0
`define SCHBP_BCR_SWAP_EN_BIT  1
`define SCHBP_BCR_SWAP_SEL_BIT 2
`define SCHBP_BCR_MUX_BIT      7
`define SCHBP_DMA_RST_IUS_BIT  7
`define SCHBP_MIE_BIT          3
`define SCHBP_VIS_BIT          0
`define SCHBP_CORE_SRCS        6
`define SCHBP_DMA_SRCS         4
`define SCHBP_ALL_SRCS         10
`define SCHBP_BYTE_ZERO        8'h00
`endif

// ---- core/schbp_sync2.v ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module schbp_sync2 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         clk_sys_i,
    input  wire         nrst_i,
    input  wire         ce_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;
    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            meta <= INIT;
            q_o  <= INIT;
        end else if (ce_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // schbp_sync2

// ---- core/schbp_prio.v ----
// fixed-priority daisy chain over all internal sources, bit 0 highest
`timescale 1ns/10ps
`include "schbp_defs.vh"
module schbp_prio (
    input  wire [`SCHBP_ALL_SRCS-1:0] pend_i,
    input  wire [`SCHBP_ALL_SRCS-1:0] ius_i,
    input  wire                       chain_in_i,
    output reg  [`SCHBP_ALL_SRCS-1:0] grant_o,
    output reg                        chain_out_o,
    output reg                        req_o
);
    integer i;
    reg     open;
    always @* begin
        open        = chain_in_i;
        grant_o     = {`SCHBP_ALL_SRCS{1'b0}};
        req_o       = 1'b0;
        // an ius blocks everything below it; core bits sit above dma
        for (i = 0; i < `SCHBP_ALL_SRCS; i = i + 1) begin
            if (open && pend_i[i] && !req_o) begin
                grant_o[i] = 1'b1;
                req_o      = 1'b1;
            end
            if (ius_i[i])
                open = 1'b0;
        end
        chain_out_o = open && !req_o;
    end
endmodule // schbp_prio

// ---- core/schbp_host_port.v ----
// host bus interface unit: bus detect, pointers, lanes, interrupt chain
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "schbp_defs.vh"
module schbp_host_port (
    input  wire                        clk_sys_i,
    input  wire                        nrst_i,
    input  wire                        ce_i,
    input  wire                        addr_strobe_n_i,
    input  wire [5:0]                  ad_addr_i,
    input  wire                        core_dma_select_i,
    input  wire                        channel_select_i,
    input  wire                        wr_i,
    input  wire                        rd_i,
    input  wire [15:0]                 data_i,
    output reg  [15:0]                 rdata_o,
    input  wire                        irq_acknowledge_n_i,
    input  wire                        chain_enable_in_i,
    output reg                         chain_enable_out_o,
    output reg                         irq_req_n_o,
    output reg  [15:0]                 ack_vector_o,
    input  wire [`SCHBP_CORE_SRCS-1:0] core_event_i,
    input  wire [`SCHBP_DMA_SRCS-1:0]  dma_event_i,
    input  wire [7:0]                  core_status_i,
    input  wire [7:0]                  core_rx_data_i,
    input  wire                        dma_to_mem_i,
    input  wire                        dma_from_mem_i,
    input  wire                        dma_addr0_i,
    input  wire [7:0]                  dma_out_byte_i,
    output reg  [15:0]                 dma_wdata_o,
    output reg  [7:0]                  dma_in_byte_o,
    output reg                         dma_in_valid_o,
    output reg                         reg_we_o,
    output reg                         reg_core_o,
    output reg                         reg_chan_o,
    output reg  [4:0]                  reg_idx_o,
    output reg  [7:0]                  reg_wdata_o,
    output reg                         bus_muxed_o
);
// ************************************************************
// functions
// ************************************************************
    function [4:0] shift_decode;
        input [5:0] ad;
        input       left;
        begin
            shift_decode = left ? ad[5:1] : ad[4:0];
        end
    endfunction
    function [7:0] lane_pick;
        input [15:0] d;
        input        upper;
        begin
            lane_pick = upper ? d[15:8] : d[7:0];
        end
    endfunction
// ************************************************************
// pin synchronisers
// ************************************************************
    wire [5:0]  s_ad;
    wire        s_as_n;
    wire        s_sel;
    wire        s_chan;
    wire        s_ack_n;
    wire        s_iei;
    wire [15:0] s_data;
    schbp_sync2 #(.W(6), .INIT(6'h00)) u_sync_ad (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .d_i       (ad_addr_i),
        .q_o       (s_ad)
    );
    schbp_sync2 #(.W(5), .INIT(5'h1f)) u_sync_ctl (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .d_i       ({addr_strobe_n_i, core_dma_select_i, channel_select_i, irq_acknowledge_n_i,
                     chain_enable_in_i}),
        .q_o       ({s_as_n, s_sel, s_chan, s_ack_n, s_iei})
    );
    schbp_sync2 #(.W(16), .INIT(16'h0000)) u_sync_data (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .d_i       (data_i),
        .q_o       (s_data)
    );
// ************************************************************
// state
// ************************************************************
    reg        cfg_done;
    reg        as_seen;
    reg [7:0]  bus_config_reg;
    reg [3:0]  core_ptr;
    reg [4:0]  dma_ptr;
    reg        core_left;
    reg [7:0]  core_vec;
    reg [7:0]  dma_vec;
    reg        core_mie;
    reg        core_vis;
    reg        dma_mie;
    reg [`SCHBP_CORE_SRCS-1:0] core_ien;
    reg [`SCHBP_DMA_SRCS-1:0]  dma_ien;
    reg [`SCHBP_ALL_SRCS-1:0]  pend;
    reg [`SCHBP_ALL_SRCS-1:0]  irq_under_service_bit;
    reg        ack_q;
    reg        wr_q;
    reg        rd_q;
    wire [`SCHBP_ALL_SRCS-1:0] grant;
    wire       chain_out;
    wire       any_req;
    wire [7:0] wbyte = s_data[7:0];
    wire       ack_edge = !s_ack_n && !ack_q;
    wire       wr_edge = wr_i && !wr_q;
    wire       rd_edge = rd_i && !rd_q;
    // mux: ad lines decoded per cell shift mode; otherwise pointer sequences
    wire       muxed = bus_config_reg[`SCHBP_BCR_MUX_BIT];
    wire [4:0] mux_idx = shift_decode(s_ad, s_sel ? core_left
                                            : bus_config_reg[`SCHBP_BCR_SHIFT_BIT]);
    wire [4:0] core_idx = muxed ? mux_idx : {1'b0, core_ptr};
    wire [4:0] dma_idx = muxed ? mux_idx : dma_ptr;
    wire [`SCHBP_ALL_SRCS-1:0] ien_all = {dma_ien, core_ien};
    wire [`SCHBP_ALL_SRCS-1:0] mie_all = {{`SCHBP_DMA_SRCS{dma_mie}}, {`SCHBP_CORE_SRCS{core_mie}}};
    schbp_prio u_prio (
        .pend_i      (pend & ien_all & mie_all),
        .ius_i       (irq_under_service_bit),
        .chain_in_i  (s_iei),
        .grant_o     (grant),
        .chain_out_o (chain_out),
        .req_o       (any_req)
    );
    // highest active ius bit, for the reset command
    reg [`SCHBP_ALL_SRCS-1:0] top_ius;
    integer k;
    always @* begin
        top_ius = {`SCHBP_ALL_SRCS{1'b0}};
        for (k = `SCHBP_ALL_SRCS - 1; k >= 0; k = k - 1) begin
            if (irq_under_service_bit[k])
                top_ius = {`SCHBP_ALL_SRCS{1'b0}} | ({{(`SCHBP_ALL_SRCS-1){1'b0}}, 1'b1} << k);
        end
    end
    reg [3:0] cause;
    integer j;
    always @* begin
        cause = 4'h0;
        for (j = `SCHBP_ALL_SRCS - 1; j >= 0; j = j - 1) begin
            if (grant[j])
                cause = j[3:0];
        end
    end
    wire core_won = |grant[`SCHBP_CORE_SRCS-1:0];
    // a reset-ius command landing in the acknowledge cycle must not be lost
    wire ius_clr = wr_edge && cfg_done && (s_sel ? (core_idx == `SCHBP_CORE_CMD_IDX &&
                   wbyte[7:`SCHBP_CMD_CODE_LSB] == `SCHBP_CMD_RESET_IUS)
                   : (dma_idx == `SCHBP_DMA_DMA_CMD_STATUS_ADDR_REG_IDX && wbyte[`SCHBP_DMA_RST_IUS_BIT]));
    wire [7:0] next_vec = core_won ? (core_vis ? {core_vec[7:4], cause[2:0], core_vec[0]} : core_vec)
                                   : (dma_vec[`SCHBP_VIS_BIT] ? {dma_vec[7:3], cause[2:0]} : dma_vec);
// ************************************************************
// register access
// ************************************************************
    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_done           <= 1'b0;
            as_seen            <= 1'b0;
            bus_config_reg     <= `SCHBP_BYTE_ZERO;
            core_ptr           <= 4'h0;
            dma_ptr            <= 5'h00;
            core_left          <= 1'b0;
            core_vec           <= `SCHBP_BYTE_ZERO;
            dma_vec            <= `SCHBP_BYTE_ZERO;
            core_mie           <= 1'b0;
            core_vis           <= 1'b0;
            dma_mie            <= 1'b0;
            core_ien           <= {`SCHBP_CORE_SRCS{1'b0}};
            dma_ien            <= {`SCHBP_DMA_SRCS{1'b0}};
            pend               <= {`SCHBP_ALL_SRCS{1'b0}};
            irq_under_service_bit                <= {`SCHBP_ALL_SRCS{1'b0}};
            ack_q              <= 1'b0;
            wr_q               <= 1'b0;
            rd_q               <= 1'b0;
            rdata_o            <= 16'h0000;
            chain_enable_out_o <= 1'b0;
            irq_req_n_o        <= 1'b1;
            ack_vector_o       <= 16'h0000;
            dma_wdata_o        <= 16'h0000;
            dma_in_byte_o      <= `SCHBP_BYTE_ZERO;
            dma_in_valid_o     <= 1'b0;
            reg_we_o           <= 1'b0;
            reg_core_o         <= 1'b0;
            reg_chan_o         <= 1'b0;
            reg_idx_o          <= 5'h00;
            reg_wdata_o        <= `SCHBP_BYTE_ZERO;
            bus_muxed_o        <= 1'b0;
        end else if (ce_i) begin
            ack_q    <= !s_ack_n;
            wr_q     <= wr_i;
            rd_q     <= rd_i;
            reg_we_o <= 1'b0;
            if (!s_as_n)
                as_seen <= 1'b1;
            // pending: core needs enable, dma does not; set wins over clear
            pend <= pend | ({dma_event_i, core_event_i & core_ien});
            if (wr_edge && !cfg_done) begin
                // config is written once per reset; mode bit records bus type
                cfg_done       <= 1'b1;
                bus_config_reg <= {as_seen || !s_as_n, wbyte[6:0]};
                bus_muxed_o    <= as_seen || !s_as_n;
            end else if (wr_edge) begin
                reg_we_o    <= 1'b1;
                reg_core_o  <= s_sel;
                reg_chan_o  <= s_chan;
                reg_wdata_o <= wbyte;
                if (s_sel) begin
                    reg_idx_o <= core_idx;
                    if (core_idx == `SCHBP_CORE_CMD_IDX) begin
                        if (!muxed)
                            core_ptr <= wbyte[`SCHBP_PTR4_MSB:0];
                        else
                            core_left <= wbyte[`SCHBP_CMD_SHIFT_BIT];
                        if (wbyte[7:`SCHBP_CMD_CODE_LSB] == `SCHBP_CMD_RESET_IUS)
                            irq_under_service_bit <= irq_under_service_bit & ~top_ius;
                    end else begin
                        core_ptr <= 4'h0;
                        case (core_idx)
                            `SCHBP_CORE_IVEC_IDX: core_vec <= wbyte;
                            `SCHBP_CORE_IEN_IDX:  core_ien <= wbyte[`SCHBP_CORE_SRCS-1:0];
                            `SCHBP_CORE_MIE_IDX: begin
                                core_mie <= wbyte[`SCHBP_MIE_BIT];
                                core_vis <= wbyte[`SCHBP_VIS_BIT];
                            end
                            `SCHBP_CORE_IPEND_IDX: pend[`SCHBP_CORE_SRCS-1:0] <= (core_event_i & core_ien) |
                                (pend[`SCHBP_CORE_SRCS-1:0] & ~wbyte[`SCHBP_CORE_SRCS-1:0]);
                            default: core_ptr <= 4'h0;
                        endcase
                    end
                end else begin
                    reg_idx_o <= dma_idx;
                    if (dma_idx == `SCHBP_DMA_DMA_CMD_STATUS_ADDR_REG_IDX) begin
                        if (!muxed)
                            dma_ptr <= wbyte[`SCHBP_PTR5_MSB:0];
                        if (wbyte[`SCHBP_DMA_RST_IUS_BIT])
                            irq_under_service_bit <= irq_under_service_bit & ~top_ius;
                    end else begin
                        dma_ptr <= 5'h00;
                        case (dma_idx)
                            `SCHBP_DMA_IVEC_IDX: dma_vec <= wbyte;
                            `SCHBP_DMA_IEN_IDX:  dma_ien <= wbyte[`SCHBP_DMA_SRCS-1:0];
                            `SCHBP_DMA_MIE_IDX:  dma_mie <= wbyte[`SCHBP_MIE_BIT];
                            `SCHBP_DMA_IPEND_IDX: pend[`SCHBP_ALL_SRCS-1:`SCHBP_CORE_SRCS] <=
                                dma_event_i | (pend[`SCHBP_ALL_SRCS-1:`SCHBP_CORE_SRCS] & ~wbyte[3:0]);
                            default: dma_ptr <= 5'h00;
                        endcase
                    end
                end
            end
            if (rd_edge) begin
                // read byte driven on both lanes
                if (s_sel) begin
                    if (core_idx != `SCHBP_CORE_CMD_IDX)
                        core_ptr <= 4'h0;
                    case (core_idx)
                        `SCHBP_CORE_CMD_IDX:   rdata_o <= {2{core_status_i}};
                        `SCHBP_CORE_DATA_IDX:  rdata_o <= {2{core_rx_data_i}};
                        `SCHBP_CORE_IVEC_IDX:  rdata_o <= {2{core_vec}};
                        `SCHBP_CORE_IPEND_IDX: rdata_o <= {2{2'b00, pend[`SCHBP_CORE_SRCS-1:0]}};
                        default:               rdata_o <= 16'h0000;
                    endcase
                end else begin
                    if (dma_idx != `SCHBP_DMA_DMA_CMD_STATUS_ADDR_REG_IDX)
                        dma_ptr <= 5'h00;
                    case (dma_idx)
                        `SCHBP_DMA_DMA_CMD_STATUS_ADDR_REG_IDX:  rdata_o <= {2{3'b000, dma_ptr}};
                        `SCHBP_DMA_IVEC_IDX:  rdata_o <= {2{dma_vec}};
                        `SCHBP_DMA_IEN_IDX:   rdata_o <= {2{4'h0, dma_ien}};
                        `SCHBP_DMA_MIE_IDX:   rdata_o <= {2{4'h0, dma_mie, 3'b000}};
                        `SCHBP_DMA_IPEND_IDX: rdata_o <= {2{4'h0, pend[`SCHBP_ALL_SRCS-1:`SCHBP_CORE_SRCS]}};
                        default:              rdata_o <= 16'h0000;
                    endcase
                end
            end
            // ************************************************************
            // interrupt chain
            // ************************************************************
            irq_req_n_o        <= !any_req;
            chain_enable_out_o <= chain_out;
            if (ack_edge && any_req) begin
                irq_under_service_bit          <= (irq_under_service_bit & ~(ius_clr ? top_ius : {`SCHBP_ALL_SRCS{1'b0}})) | grant;
                pend         <= (pend & ~grant) | {dma_event_i, core_event_i & core_ien};
                ack_vector_o <= {2{next_vec}};
            end
            // ************************************************************
            // dma byte lanes
            // ************************************************************
            dma_wdata_o    <= dma_to_mem_i ? {2{dma_out_byte_i}} : 16'h0000;
            dma_in_valid_o <= dma_from_mem_i;
            dma_in_byte_o  <= lane_pick(s_data, bus_config_reg[`SCHBP_BCR_SWAP_EN_BIT] &&
                              (bus_config_reg[`SCHBP_BCR_SWAP_SEL_BIT] ? dma_addr0_i : !dma_addr0_i));
        end
    end
endmodule // schbp_host_port

// ---- bench/schbp_host_port_asserts.sv ----
// concurrent checks on the host bus port pins
`timescale 1ns/10ps
module schbp_host_port_asserts (
    input wire        clk_sys_i,
    input wire        nrst_i,
    input wire        addr_strobe_n_i,
    input wire        wr_i,
    input wire        chain_enable_in_i,
    input wire        irq_acknowledge_n_i,
    input wire [15:0] rdata_o,
    input wire [15:0] ack_vector_o,
    input wire [15:0] dma_wdata_o,
    input wire        chain_enable_out_o,
    input wire        irq_req_n_o,
    input wire        reg_we_o,
    input wire        bus_muxed_o
);
    reg       as_seen;
    reg [3:0] ack_age;
    // ack_age saturates, so an old acknowledge never excuses a vector change
    always @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            as_seen <= 1'b0;
            ack_age <= 4'hf;
        end else begin
            as_seen <= as_seen | ~addr_strobe_n_i;
            ack_age <= irq_acknowledge_n_i ? ack_age + {3'h0, ~&ack_age} : 4'h0;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_rd_lanes; rdata_o[15:8] == rdata_o[7:0]; endproperty
    a_rd_lanes: assert property (p_rd_lanes) else $error("read byte not on both lanes");
    property p_vec_lanes; ack_vector_o[15:8] == ack_vector_o[7:0]; endproperty
    a_vec_lanes: assert property (p_vec_lanes) else $error("vector not on both lanes");
    property p_dma_lanes; dma_wdata_o[15:8] == dma_wdata_o[7:0]; endproperty
    a_dma_lanes: assert property (p_dma_lanes) else $error("dma byte not replicated");
    property p_chain_block; !chain_enable_in_i [*4] |-> irq_req_n_o && !chain_enable_out_o; endproperty
    a_chain_block: assert property (p_chain_block) else $error("request while chain input low");
    property p_mux_cause; $rose(bus_muxed_o) |-> as_seen; endproperty
    a_mux_cause: assert property (p_mux_cause) else $error("muxed bus without strobe");
    property p_mux_hold; !$fell(bus_muxed_o); endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("bus type changed");
    property p_ack_cause; $changed(ack_vector_o) |-> ack_age <= 4'h5; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("vector changed without acknowledge");
    property p_we_cause; reg_we_o |-> $past(wr_i) || $past(wr_i, 2); endproperty
    a_we_cause: assert property (p_we_cause) else $error("register write without strobe");
endmodule // schbp_host_port_asserts

bind schbp_host_port schbp_host_port_asserts i_schbp_host_port_asserts (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_strobe_n_i(addr_strobe_n_i), .wr_i(wr_i),
    .chain_enable_in_i(chain_enable_in_i), .irq_acknowledge_n_i(irq_acknowledge_n_i), .rdata_o(rdata_o),
    .ack_vector_o(ack_vector_o), .dma_wdata_o(dma_wdata_o), .chain_enable_out_o(chain_enable_out_o),
    .irq_req_n_o(irq_req_n_o), .reg_we_o(reg_we_o), .bus_muxed_o(bus_muxed_o));

// ---- bench/schbp_host_model.sv ----
// host cpu model driving the bus port pins
`timescale 1ns/10ps
module schbp_host_model (
    input  wire        clk_sys_i,
    input  wire [15:0] rdata_i,
    output reg         addr_strobe_n_o = 1'b1,
    output reg  [5:0]  ad_addr_o = 6'h00,
    output reg         sel_core_o = 1'b1,
    output reg         chan_o = 1'b0,
    output reg         wr_o = 1'b0,
    output reg         rd_o = 1'b0,
    output reg  [15:0] data_o = 16'h0000,
    output reg         ack_n_o = 1'b1
);
    // address and data lead the strobe by three cycles: the port sees them through
    // two-stage synchronisers; the first write after reset carries the config byte
    task xfer(input logic as, input logic core, input logic rd, input logic [5:0] ad,
              input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys_i);
        addr_strobe_n_o <= ~as;
        sel_core_o      <= core;
        ad_addr_o       <= ad;
        data_o          <= rd ? ~data_o : d;
        repeat (3) @(posedge clk_sys_i);
        wr_o <= ~rd;
        rd_o <= rd;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        addr_strobe_n_o <= 1'b1;
        // a released bus shows no stale copy of the last value
        data_o <= ~data_o;
        q = rdata_i;
    endtask
    task put_data(input logic [15:0] d);
        data_o <= d;
    endtask
    // held four cycles so the synchronised falling edge is seen
    task ack();
        ack_n_o <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        ack_n_o <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
    endtask
endmodule // schbp_host_model

// ---- bench/schbp_host_port_tb_top.sv ----
// self-checking testbench for the host bus port
`timescale 1ns/10ps
module schbp_host_port_tb_top;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b0, chain_in = 1'b1, to_mem = 1'b0, from_mem = 1'b0, addr0 = 1'b0;
    logic [5:0]  core_ev = 6'h00;
    logic [3:0]  dma_ev = 4'h0;
    logic [7:0]  out_byte = 8'h00, cap_wd = 8'h00;
    logic [4:0]  cap_idx = 5'h00;
    logic        cap_core = 1'b0, cap_chan = 1'b0;
    logic [15:0] q;
    wire         as_n, sel, chan, wr_s, rd_s, ack_n, chain_enable_out, irq_n, we, rcore, rchan, muxed, in_valid;
    wire  [5:0]  ad;
    wire  [15:0] data, rdata, vec, dwdata;
    wire  [4:0]  ridx;
    wire  [7:0]  rwdata, in_byte;
    int          bad_count = 0, compares = 0, cyc = 0;
    schbp_host_port i_schbp_host_port (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .addr_strobe_n_i(as_n), .ad_addr_i(ad), .core_dma_select_i(sel), .channel_select_i(chan), .wr_i(wr_s),
        .rd_i(rd_s), .data_i(data), .rdata_o(rdata), .irq_acknowledge_n_i(ack_n), .chain_enable_in_i(chain_in),
        .chain_enable_out_o(chain_enable_out), .irq_req_n_o(irq_n), .ack_vector_o(vec), .core_event_i(core_ev),
        .dma_event_i(dma_ev), .core_status_i(8'h6d), .core_rx_data_i(8'h91), .dma_to_mem_i(to_mem),
        .dma_from_mem_i(from_mem), .dma_addr0_i(addr0), .dma_out_byte_i(out_byte), .dma_wdata_o(dwdata),
        .dma_in_byte_o(in_byte), .dma_in_valid_o(in_valid), .reg_we_o(we), .reg_core_o(rcore), .reg_chan_o(rchan),
        .reg_idx_o(ridx), .reg_wdata_o(rwdata), .bus_muxed_o(muxed));
    schbp_host_model i_schbp_host_model (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_strobe_n_o(as_n),
        .ad_addr_o(ad), .sel_core_o(sel), .chan_o(chan), .wr_o(wr_s), .rd_o(rd_s), .data_o(data), .ack_n_o(ack_n));
    always #10 clk_sys_i = ~clk_sys_i;
    // write pulses last one cycle, so they are caught here; the run needs under 2500 cycles
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (we === 1'b1) begin
            cap_core <= rcore;
            cap_chan <= rchan;
            cap_idx  <= ridx;
            cap_wd   <= rwdata;
        end
        if (cyc == 4000) begin
            bad_count++;
            print_verdict();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input logic core, input logic [15:0] d);
        i_schbp_host_model.xfer(1'b0, core, 1'b0, 6'h00, d, q);
    endtask
    task rd(input logic core);
        i_schbp_host_model.xfer(1'b0, core, 1'b1, 6'h00, 16'h0000, q);
    endtask
    task do_reset();
        tick(1);
        nrst_i <= 1'b0;
        tick(6);
        nrst_i <= 1'b1;
        tick(3);
    endtask
    task t_core_ptr();
        do_reset();
        wr(1'b1, 16'h0002);
        check(16'(muxed), 16'h0000);
        i_schbp_host_model.xfer(1'b1, 1'b1, 1'b0, 6'h00, 16'h0000, q);
        check(16'(muxed), 16'h0000);
        wr(1'b1, 16'hc308);
        wr(1'b1, 16'h3c5a);
        check({cap_core, cap_chan, 1'b0, cap_idx, cap_wd}, 16'h885a);
        wr(1'b1, 16'h0008);
        rd(1'b1);
        check(q, 16'h9191);
        rd(1'b1);
        check(q, 16'h6d6d);
    endtask
    // memory data crosses the two-stage synchroniser, hence the five-cycle waits
    task t_lanes(input logic [7:0] even_b, input logic [7:0] odd_b);
        to_mem   <= 1'b1;
        out_byte <= 8'ha7;
        addr0    <= 1'b0;
        tick(4);
        check(dwdata, 16'ha7a7);
        to_mem   <= 1'b0;
        from_mem <= 1'b1;
        i_schbp_host_model.put_data(16'h5c3a);
        tick(5);
        check({8'h00, in_byte}, {8'h00, even_b});
        check(16'(in_valid), 16'h0001);
        addr0 <= 1'b1;
        tick(5);
        check({8'h00, in_byte}, {8'h00, odd_b});
        from_mem <= 1'b0;
    endtask
    task t_irq();
        wr(1'b0, 16'h0002);
        wr(1'b0, 16'h000f);
        wr(1'b0, 16'h0002);
        rd(1'b0);
        check(q, 16'h0f0f);
        wr(1'b0, 16'h0001);
        wr(1'b0, 16'h0040);
        wr(1'b0, 16'h0003);
        wr(1'b0, 16'h0008);
        chain_in <= 1'b0;
        core_ev  <= 6'h01;
        dma_ev   <= 4'h1;
        tick(1);
        core_ev  <= 6'h00;
        dma_ev   <= 4'h0;
        tick(6);
        check(16'(irq_n), 16'h0001);
        wr(1'b0, 16'h0004);
        rd(1'b0);
        check(q, 16'h0101);
        wr(1'b1, 16'h0003);
        rd(1'b1);
        check(q, 16'h0000);
        chain_in <= 1'b1;
        tick(6);
        check(16'(irq_n), 16'h0000);
        i_schbp_host_model.ack();
        check(vec, 16'h4040);
        check({14'h0000, chain_enable_out, irq_n}, 16'h0001);
        wr(1'b0, 16'h0080);
        tick(3);
        check(16'(chain_enable_out), 16'h0001);
    endtask
    task t_mux();
        do_reset();
        i_schbp_host_model.xfer(1'b1, 1'b1, 1'b0, 6'h3f, 16'h0006, q);
        check(16'(muxed), 16'h0001);
        i_schbp_host_model.chan_o <= 1'b1;
        i_schbp_host_model.xfer(1'b1, 1'b1, 1'b0, 6'h3f, 16'h0033, q);
        check({cap_core, cap_chan, 1'b0, cap_idx, cap_wd}, 16'hdf33);
        i_schbp_host_model.xfer(1'b1, 1'b0, 1'b0, 6'h3f, 16'h0044, q);
        check({cap_core, cap_chan, 1'b0, cap_idx, cap_wd}, 16'h5f44);
        i_schbp_host_model.xfer(1'b1, 1'b1, 1'b0, 6'h00, 16'h0001, q);
        i_schbp_host_model.xfer(1'b1, 1'b1, 1'b0, 6'h3e, 16'h0055, q);
        check({cap_core, cap_chan, 1'b0, cap_idx, cap_wd}, 16'hdf55);
        t_lanes(8'h3a, 8'h5c);
    endtask
    initial begin
        t_core_ptr();
        t_lanes(8'h5c, 8'h3a);
        t_irq();
        t_mux();
        print_verdict();
    end
endmodule // schbp_host_port_tb_top
